/* File: asd_params.svh */
// asd_params.svh: task-file field positions, command and subcommand codes, timing counts
// assumes inclusion by both ends and the seek timer; definitions only
`ifndef ASD_PARAMS_SVH
`define ASD_PARAMS_SVH
// command codes
`define ASD_CMD_SEEK_NIB   4'h7
`define ASD_CMD_SETFEAT    8'hef
`define ASD_CMD_SETMAX     8'hf9
`define ASD_CMD_READMAX    8'hf8
`define ASD_SETMAX_FEAT    8'h00
// set-features subcommands
`define ASD_SF_XFER        8'h03
`define ASD_SF_APM_ON      8'h05
`define ASD_SF_APM_OFF     8'h85
`define ASD_SF_AOFS_ON     8'h09
`define ASD_SF_AOFS_OFF    8'h89
`define ASD_SF_ECC24       8'h44
`define ASD_SF_ECC4        8'hbb
`define ASD_SF_RLA_OFF     8'h55
`define ASD_SF_RLA_ON      8'haa
`define ASD_SF_NOREV       8'h66
`define ASD_SF_REV         8'hcc
`define ASD_SF_WC_ON       8'h02
`define ASD_SF_WC_OFF      8'h82
`define ASD_SF_RETRY_ON    8'h99
`define ASD_SF_RETRY_OFF   8'h33
`define ASD_SF_ECC_ON      8'h88
`define ASD_SF_ECC_OFF     8'h77
// transfer mode codes: upper nibble class, lower nibble mode number
`define ASD_XM_MWDMA       4'h2
`define ASD_XM_UDMA        4'h4
`define ASD_XM_MWDMA_MAX   4'h2
`define ASD_XM_UDMA_MAX    4'h5
// ecc field lengths in bytes
`define ASD_ECC_LONG       8'h18
`define ASD_ECC_SHORT      8'h04
// field positions
`define ASD_DH_LBA_BIT     6
`define ASD_SC_PERSIST_BIT 0
// reset values
`define ASD_RST_XMODE      8'h40
`define ASD_RST_MAXADDR    28'hfffffff
// mechanical seek time, default 2000 ns
`define ASD_SEEK_NS        2000
`define ASD_CLK_NS         5
`define ASD_SEEK_CYC       ((`ASD_SEEK_NS + `ASD_CLK_NS - 1) / `ASD_CLK_NS)
`endif

/* File: asd_pkg.sv */
// asd_pkg.sv: shared types for the seek/set-features decoder ends
// assumes asd_params.svh supplies the numbers
package asd_pkg;
    typedef enum logic [1:0] {
        ASD_IDLE = 2'b00,
        ASD_WAIT = 2'b01,
        ASD_EXEC = 2'b11
    } asd_state_t;

    typedef enum logic [1:0] {
        ASD_OK    = 2'b00,
        ASD_ABORT = 2'b01
    } asd_result_t;
endpackage

/* File: asd_taskfile_if.sv */
// asd_taskfile_if.sv: task-file link between host controller and drive
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface asd_taskfile_if (
    input wire logic clk
);
    logic [7:0] command_code_reg;
    logic [7:0] feature_select;
    logic [7:0] block_count_param;
    logic [7:0] addr_lower_byte;
    logic [7:0] addr_middle_byte;
    logic [7:0] addr_upper_byte;
    logic [7:0] drive_select_head;
    logic       cmd_wr;
    logic       busy;
    logic       intrq;
    logic       abort;

    modport drive (
        input  command_code_reg, feature_select, block_count_param, addr_lower_byte,
               addr_middle_byte, addr_upper_byte, drive_select_head, cmd_wr,
        output busy, intrq, abort
    );
    modport host (
        output command_code_reg, feature_select, block_count_param, addr_lower_byte,
               addr_middle_byte, addr_upper_byte, drive_select_head, cmd_wr,
        input  busy, intrq, abort
    );
endinterface

/* File: asd_seek_timer.sv */
// asd_seek_timer.sv: mechanical seek stand-in, busy for a fixed count after start
// assumes start is a one-cycle pulse on clk
`timescale 1ns/1ps
`include "asd_params.svh"
module asd_seek_timer #(
    parameter int SEEK_CYC = `ASD_SEEK_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      active
);
    logic [31:0] cnt_r;

    // ****************************************
    // countdown
    // ****************************************
    // a restart while active reloads; the head simply retargets
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 32'h0;
        end else if (start) begin
            cnt_r <= 32'(SEEK_CYC);
        end else if (cnt_r != 32'h0) begin
            cnt_r <= cnt_r - 32'h1;
        end
    end

    assign active = (cnt_r != 32'h0);
endmodule // asd_seek_timer

/* File: asd_drive.sv */
// asd_drive.sv: drive end, decodes seek, set-features and set-max commands
// assumes host writes task file then pulses cmd_wr once per command
// Contract
// - any 7x command code is a seek
// - chs seek: cylinder high, mid, sector, head
// - lba seek: 28-bit address over four registers
// - seek completion interrupt precedes mechanical finish
// - command during seek: busy until seek ends
// - set-features efh: subcommand in features, argument count
// - subcommand 03h selects transfer mode from count
// - 2xh selects multiword dma mode 0..2
// - 4xh selects ultra dma mode 0..5
// - 05h enables, 85h disables power management
// - 09h enables, 89h disables address offset
// - 44h makes long transfers carry 24-byte ecc
// - bbh restores 4-byte long ecc field
// - 55h read look-ahead off, aah on
// - 66h stops reverting defaults, cch re-enables
// - unsupported subcommand aborts the command
// - set-max f9h with features 00h
// - lba set-max address over four registers
// - count bit 0 selects persistent limit
// - set-max needs read-max immediately before
`timescale 1ns/1ps
`include "asd_params.svh"
module asd_drive #(
    parameter int SEEK_CYC = `ASD_SEEK_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       soft_rst,
    asd_taskfile_if.drive   tf,
    output logic [7:0]      xfer_mode_r,
    output logic            apm_en_r,
    output logic            addr_ofs_en_r,
    output logic [7:0]      ecc_len_r,
    output logic            read_ahead_en_r,
    output logic            revert_en_r,
    output logic            wcache_en_r,
    output logic            retry_en_r,
    output logic            ecc_en_r,
    output logic [27:0]     max_addr_r,
    output logic            max_persist_r,
    output logic [27:0]     seek_target_r,
    output logic            seek_lba_r
);
    asd_pkg::asd_state_t state_r;
    asd_pkg::asd_state_t state_nxt;
    logic [7:0]  cmd_r, feat_r, cnt_r, lo_r, mid_r, hi_r, dh_r;
    logic        readmax_ok_r, seek_start, seek_active, exec, is_seek, sf_ok, xm_ok, sm_ok;
    logic        abort_nxt, intrq_r, abort_r;

    asd_seek_timer #(
        .SEEK_CYC (SEEK_CYC)
    ) u_seek (
        .clk      (clk),
        .rst      (rst),
        .start    (seek_start),
        .active   (seek_active)
    );

    // ****************************************
    // command capture
    // ****************************************
    // latch the task file so the host may rewrite it while we stall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_r  <= 8'h00;
            feat_r <= 8'h00;
            cnt_r  <= 8'h00;
            lo_r   <= 8'h00;
            mid_r  <= 8'h00;
            hi_r   <= 8'h00;
            dh_r   <= 8'h00;
        end else if (tf.cmd_wr && state_r == asd_pkg::ASD_IDLE) begin
            cmd_r  <= tf.command_code_reg;
            feat_r <= tf.feature_select;
            cnt_r  <= tf.block_count_param;
            lo_r   <= tf.addr_lower_byte;
            mid_r  <= tf.addr_middle_byte;
            hi_r   <= tf.addr_upper_byte;
            dh_r   <= tf.drive_select_head;
        end
    end

    // ****************************************
    // sequencing
    // ****************************************
    // new command waits out a running seek before it executes
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            asd_pkg::ASD_IDLE: begin
                if (tf.cmd_wr) begin
                    state_nxt = asd_pkg::ASD_WAIT;
                end
            end
            asd_pkg::ASD_WAIT: begin
                if (!seek_active) begin
                    state_nxt = asd_pkg::ASD_EXEC;
                end
            end
            asd_pkg::ASD_EXEC: begin
                state_nxt = asd_pkg::ASD_IDLE;
            end
            default: begin
                state_nxt = asd_pkg::ASD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= asd_pkg::ASD_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign exec    = (state_r == asd_pkg::ASD_EXEC);
    assign is_seek = (cmd_r[7:4] == `ASD_CMD_SEEK_NIB);
    assign seek_start = exec && is_seek;
    // busy covers the wait, never the seek itself
    assign tf.busy = (state_r != asd_pkg::ASD_IDLE);

    // ****************************************
    // decode checks
    // ****************************************
    always_comb begin
        xm_ok = ((cnt_r[7:4] == `ASD_XM_MWDMA) && (cnt_r[3:0] <= `ASD_XM_MWDMA_MAX))
             || ((cnt_r[7:4] == `ASD_XM_UDMA) && (cnt_r[3:0] <= `ASD_XM_UDMA_MAX));
        case (feat_r)
            `ASD_SF_XFER:                                    sf_ok = xm_ok;
            `ASD_SF_APM_ON, `ASD_SF_APM_OFF,
            `ASD_SF_AOFS_ON, `ASD_SF_AOFS_OFF,
            `ASD_SF_ECC24, `ASD_SF_ECC4,
            `ASD_SF_RLA_OFF, `ASD_SF_RLA_ON,
            `ASD_SF_NOREV, `ASD_SF_REV,
            `ASD_SF_WC_ON, `ASD_SF_WC_OFF,
            `ASD_SF_RETRY_ON, `ASD_SF_RETRY_OFF,
            `ASD_SF_ECC_ON, `ASD_SF_ECC_OFF:                 sf_ok = 1'b1;
            default:                                         sf_ok = 1'b0;
        endcase
        // persistent limit refused in offset mode; read-max must precede
        sm_ok = (feat_r == `ASD_SETMAX_FEAT) && readmax_ok_r
             && !(cnt_r[`ASD_SC_PERSIST_BIT] && addr_ofs_en_r);
        abort_nxt = 1'b0;
        if (cmd_r == `ASD_CMD_SETFEAT) begin
            abort_nxt = !sf_ok;
        end else if (cmd_r == `ASD_CMD_SETMAX) begin
            abort_nxt = !sm_ok;
        end
    end

    // ****************************************
    // completion
    // ****************************************
    // seek reports done at its start, ahead of the mechanics
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intrq_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            intrq_r <= exec;
            if (exec) begin
                abort_r <= abort_nxt;
            end
        end
    end
    assign tf.intrq = intrq_r;
    assign tf.abort = abort_r;

    // read-max must be the command right before set-max
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readmax_ok_r <= 1'b0;
        end else if (exec) begin
            readmax_ok_r <= (cmd_r == `ASD_CMD_READMAX);
        end
    end

    // ****************************************
    // seek target
    // ****************************************
    // chs packs cyl[15:0], head[3:0], sector[7:0] into the same 28 bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seek_target_r <= 28'h0;
            seek_lba_r    <= 1'b0;
        end else if (seek_start) begin
            seek_lba_r <= dh_r[`ASD_DH_LBA_BIT];
            if (dh_r[`ASD_DH_LBA_BIT]) begin
                seek_target_r <= {dh_r[3:0], hi_r, mid_r, lo_r};
            end else begin
                seek_target_r <= {hi_r, mid_r, dh_r[3:0], lo_r};
            end
        end
    end

    // ****************************************
    // feature state
    // ****************************************
    // soft reset restores defaults only while reverting is enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xfer_mode_r     <= `ASD_RST_XMODE;
            apm_en_r        <= 1'b0;
            addr_ofs_en_r   <= 1'b0;
            ecc_len_r       <= `ASD_ECC_SHORT;
            read_ahead_en_r <= 1'b1;
            revert_en_r     <= 1'b1;
            wcache_en_r     <= 1'b1;
            retry_en_r      <= 1'b1;
            ecc_en_r        <= 1'b1;
        end else if (soft_rst && revert_en_r) begin
            xfer_mode_r     <= `ASD_RST_XMODE;
            apm_en_r        <= 1'b0;
            addr_ofs_en_r   <= 1'b0;
            ecc_len_r       <= `ASD_ECC_SHORT;
            read_ahead_en_r <= 1'b1;
            wcache_en_r     <= 1'b1;
            retry_en_r      <= 1'b1;
            ecc_en_r        <= 1'b1;
        end else if (exec && cmd_r == `ASD_CMD_SETFEAT && sf_ok) begin
            case (feat_r)
                `ASD_SF_XFER:      xfer_mode_r     <= cnt_r;
                `ASD_SF_APM_ON:    apm_en_r        <= 1'b1;
                `ASD_SF_APM_OFF:   apm_en_r        <= 1'b0;
                `ASD_SF_AOFS_ON:   addr_ofs_en_r   <= 1'b1;
                `ASD_SF_AOFS_OFF:  addr_ofs_en_r   <= 1'b0;
                `ASD_SF_ECC24:     ecc_len_r       <= `ASD_ECC_LONG;
                `ASD_SF_ECC4:      ecc_len_r       <= `ASD_ECC_SHORT;
                `ASD_SF_RLA_OFF:   read_ahead_en_r <= 1'b0;
                `ASD_SF_RLA_ON:    read_ahead_en_r <= 1'b1;
                `ASD_SF_NOREV:     revert_en_r     <= 1'b0;
                `ASD_SF_REV:       revert_en_r     <= 1'b1;
                `ASD_SF_WC_ON:     wcache_en_r     <= 1'b1;
                `ASD_SF_WC_OFF:    wcache_en_r     <= 1'b0;
                `ASD_SF_RETRY_ON:  retry_en_r      <= 1'b1;
                `ASD_SF_RETRY_OFF: retry_en_r      <= 1'b0;
                `ASD_SF_ECC_ON:    ecc_en_r        <= 1'b1;
                `ASD_SF_ECC_OFF:   ecc_en_r        <= 1'b0;
                default:           ecc_en_r        <= ecc_en_r;
            endcase
        end
    end

    // ****************************************
    // maximum address
    // ****************************************
    // a volatile limit falls back on hardware reset only; rst stands for it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            max_addr_r    <= `ASD_RST_MAXADDR;
            max_persist_r <= 1'b0;
        end else if (exec && cmd_r == `ASD_CMD_SETMAX && sm_ok) begin
            max_persist_r <= cnt_r[`ASD_SC_PERSIST_BIT];
            if (dh_r[`ASD_DH_LBA_BIT]) begin
                max_addr_r <= {dh_r[3:0], hi_r, mid_r, lo_r};
            end else begin
                max_addr_r <= {12'h0, hi_r, mid_r};
            end
        end
    end
endmodule // asd_drive

/* File: asd_host.sv */
// asd_host.sv: host end, loads the task file and issues one command on request
// assumes the user holds req until ack; one command outstanding at a time
`timescale 1ns/1ps
`include "asd_params.svh"
module asd_host (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       req,
    input  wire logic [7:0] cmd,
    input  wire logic [7:0] feat,
    input  wire logic [7:0] count,
    input  wire logic [7:0] lo,
    input  wire logic [7:0] mid,
    input  wire logic [7:0] hi,
    input  wire logic [7:0] dh,
    output logic            ack,
    output logic            done_r,
    output logic            aborted_r,
    asd_taskfile_if.host    tf
);
    logic pend_r;
    logic fire;

    // ****************************************
    // issue
    // ****************************************
    // only issue while the drive is idle and nothing is pending
    assign fire = req && !pend_r && !tf.busy;
    assign ack  = fire;

    // task file stays put until the next command
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tf.command_code_reg  <= 8'h00;
            tf.feature_select    <= 8'h00;
            tf.block_count_param <= 8'h00;
            tf.addr_lower_byte   <= 8'h00;
            tf.addr_middle_byte  <= 8'h00;
            tf.addr_upper_byte   <= 8'h00;
            tf.drive_select_head <= 8'h00;
            tf.cmd_wr            <= 1'b0;
        end else begin
            tf.cmd_wr <= fire;
            if (fire) begin
                tf.command_code_reg  <= cmd;
                tf.feature_select    <= feat;
                tf.block_count_param <= count;
                tf.addr_lower_byte   <= lo;
                tf.addr_middle_byte  <= mid;
                tf.addr_upper_byte   <= hi;
                tf.drive_select_head <= dh;
            end
        end
    end

    // ****************************************
    // completion
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_r    <= 1'b0;
            done_r    <= 1'b0;
            aborted_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (fire) begin
                pend_r <= 1'b1;
            end else if (pend_r && tf.intrq) begin
                pend_r    <= 1'b0;
                done_r    <= 1'b1;
                aborted_r <= tf.abort;
            end
        end
    end
endmodule // asd_host

/* File: asd_link_properties.sv */
// asd_link_properties.sv: concurrent checks on the task-file link between host and drive
// assumes one clock, rst asynchronous active high, instanced beside the link by the bench
`timescale 1ns/1ps
module asd_link_properties (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] command_code_reg,
    input wire logic [7:0] feature_select,
    input wire logic [7:0] block_count_param,
    input wire logic       cmd_wr,
    input wire logic       busy,
    input wire logic       intrq,
    input wire logic       abort
);
    // ************************************
    // decode of the command held on the link
    // ************************************
    logic is_seek;
    logic is_sf;
    logic sf_known;
    logic xfer_ok;

    // task file stays put until the host's next ack, so it is still valid at intrq
    assign is_seek  = command_code_reg[7:4] == 4'h7;
    assign is_sf    = command_code_reg == 8'hef;
    assign sf_known = feature_select inside {8'h02, 8'h03, 8'h05, 8'h09, 8'h33, 8'h44, 8'h55, 8'h66,
                                             8'h77, 8'h82, 8'h85, 8'h88, 8'h89, 8'h99, 8'haa, 8'hbb, 8'hcc};
    assign xfer_ok  = block_count_param inside {[8'h20:8'h22], [8'h40:8'h45]};

    // ************************************
    // properties
    // ************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_busy_after_wr: assert property (cmd_wr |=> busy [*2])
        else $error("busy not held after a command write");
    a_answer_bound: assert property (cmd_wr |-> ##[3:20] intrq)
        else $error("command never answered");
    a_intrq_pulse: assert property (intrq |=> !intrq)
        else $error("completion pulse longer than one cycle");
    a_busy_ends: assert property (intrq |-> !busy)
        else $error("busy still up at completion");
    a_seek_holdoff: assert property (intrq && is_seek |=> !intrq [*8])
        else $error("command finished while the seek was still moving");
    a_no_wr_busy: assert property (busy |-> !cmd_wr)
        else $error("command written while busy");
    a_abort_steady: assert property ($changed(abort) |-> intrq)
        else $error("abort moved outside a completion");
    a_unsup_abort: assert property (intrq && is_sf && !sf_known |-> abort)
        else $error("unknown subcommand not aborted");
    a_xfer_code: assert property (intrq && is_sf && feature_select == 8'h03 |-> abort == !xfer_ok)
        else $error("transfer mode code judged wrongly");
    a_setmax_feat: assert property (intrq && command_code_reg == 8'hf9 && feature_select != 8'h00 |-> abort)
        else $error("set-max with nonzero feature not aborted");
    a_seek_clean: assert property (intrq && is_seek |-> !abort)
        else $error("seek aborted");
endmodule // asd_link_properties

/* File: tb.sv */
// tb.sv: self-checking bench joining host and drive ends over the task-file link
// assumes the package, params header, link interface and both ends are compiled first
`timescale 1ns/1ps
module tb;
    localparam int SEEK = 8;  // short mechanical seek keeps the run brief
    localparam int LAT0 = 5;  // ack edge to done_r when no seek is moving

    logic        clk;
    logic        rst;
    logic        soft_rst;
    logic        req;
    logic [7:0]  cmd, feat, count, lo, mid, hi, dh;
    logic        ack;
    logic        done_r;
    logic        aborted_r;
    logic [7:0]  xfer_mode;
    logic [7:0]  ecc_len;
    logic        apm_en, ofs_en, ra_en, rev_en, wc_en, rt_en, ecc_en, persist, seek_lba;
    logic [27:0] max_addr;
    logic [27:0] seek_target;
    logic [14:0] fstat;
    int          errors;
    int          n_tests;
    int          lat;

    // ************************************
    // structure
    // ************************************
    asd_taskfile_if i_asd_taskfile_if (.clk(clk));

    asd_host i_asd_host (.clk(clk), .rst(rst), .req(req), .cmd(cmd), .feat(feat), .count(count), .lo(lo),
        .mid(mid), .hi(hi), .dh(dh), .ack(ack), .done_r(done_r), .aborted_r(aborted_r), .tf(i_asd_taskfile_if));

    asd_drive #(.SEEK_CYC(SEEK)) i_asd_drive (.clk(clk), .rst(rst), .soft_rst(soft_rst), .tf(i_asd_taskfile_if),
        .xfer_mode_r(xfer_mode), .apm_en_r(apm_en), .addr_ofs_en_r(ofs_en), .ecc_len_r(ecc_len),
        .read_ahead_en_r(ra_en), .revert_en_r(rev_en), .wcache_en_r(wc_en), .retry_en_r(rt_en),
        .ecc_en_r(ecc_en), .max_addr_r(max_addr), .max_persist_r(persist), .seek_target_r(seek_target),
        .seek_lba_r(seek_lba));

    asd_link_properties i_asd_link_properties (.clk(clk), .rst(rst),
        .command_code_reg(i_asd_taskfile_if.command_code_reg), .feature_select(i_asd_taskfile_if.feature_select),
        .block_count_param(i_asd_taskfile_if.block_count_param), .cmd_wr(i_asd_taskfile_if.cmd_wr),
        .busy(i_asd_taskfile_if.busy), .intrq(i_asd_taskfile_if.intrq), .abort(i_asd_taskfile_if.abort));

    // feature flags packed so one compare covers them all
    assign fstat = {apm_en, ofs_en, ecc_len, ra_en, rev_en, wc_en, rt_en, ecc_en};

    // 200 MHz
    always #2.5 clk = ~clk;

    // ************************************
    // shared tasks
    // ************************************
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // one command through the host end; lat counts ack edge to done_r
    task automatic issue(input logic [7:0] c, f, n, l, m, h, d, output logic ab);
        int k;
        @(posedge clk);
        req   <= 1'b1;
        cmd   <= c;
        feat  <= f;
        count <= n;
        lo    <= l;
        mid   <= m;
        hi    <= h;
        dh    <= d;
        for (k = 0; k < 50 && ack !== 1'b1; k++)
            @(negedge clk);
        @(posedge clk);
        req <= 1'b0;
        for (lat = 0; lat < 60 && done_r !== 1'b1; lat++)
            @(negedge clk);
        if (k == 50 || lat == 60) begin
            errors++;
            tally_and_finish();
        end
        ab = aborted_r;
    endtask

    task automatic sf(input logic [7:0] f);
        logic ab;
        issue(8'hef, f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, ab);
    endtask

    // ************************************
    // scenarios
    // ************************************
    task automatic t_reset();
        @(negedge clk);
        check({xfer_mode, ecc_len, apm_en, ofs_en, ra_en, rev_en, wc_en, rt_en, ecc_en, persist}, 24'h40043e);
        check({4'h0, max_addr}, 32'h0fffffff);
        check({4'h0, seek_target}, 32'h0);
        $display("t_reset done");
    endtask

    // every 7x code, chs and lba alternating; later ones land on a moving seek
    task automatic t_seek();
        logic        ab;
        logic [7:0]  d;
        logic [27:0] e;
        for (int n = 0; n < 16; n++) begin
            d = {1'b0, n[0], 2'b00, n[3:0]};
            issue({4'h7, n[3:0]}, 8'h00, 8'h00, {n[3:0], 4'h1}, 8'h3c, 8'ha5, d, ab);
            e = n[0] ? {d[3:0], 8'ha5, 8'h3c, n[3:0], 4'h1} : {8'ha5, 8'h3c, d[3:0], n[3:0], 4'h1};
            check(ab, 1'b0);
            check({seek_lba, seek_target}, {n[0], e});
            if (n == 0)
                check(lat, LAT0);
            else
                check(lat > LAT0, 1'b1);
        end
        $display("t_seek done");
    endtask

    // each pair moved off its reset value then back; last five codes are unsupported
    task automatic t_features();
        logic        ab;
        logic [7:0]  code [21] = '{8'h05, 8'h85, 8'h09, 8'h89, 8'h44, 8'hbb, 8'h55, 8'haa, 8'h66, 8'hcc, 8'h82,
                                   8'h02, 8'h33, 8'h99, 8'h77, 8'h88, 8'h00, 8'h12, 8'h8a, 8'hfe, 8'hff};
        logic [14:0] want [21] = '{15'h409f, 15'h009f, 15'h209f, 15'h009f, 15'h031f, 15'h009f, 15'h008f,
                                   15'h009f, 15'h0097, 15'h009f, 15'h009b, 15'h009f, 15'h009d, 15'h009f,
                                   15'h009e, 15'h009f, 15'h009f, 15'h009f, 15'h009f, 15'h009f, 15'h009f};
        for (int i = 0; i < 21; i++) begin
            issue(8'hef, code[i], 8'h00, 8'h5a, 8'h5a, 8'h5a, 8'h00, ab);
            check(ab, i > 15);
            check(fstat, want[i]);
        end
        $display("t_features done");
    endtask

    // all 256 transfer mode codes; rejected ones leave the mode alone
    task automatic t_xfer();
        logic       ab;
        logic       ok;
        logic [7:0] m;
        m = 8'h40;
        for (int c = 0; c < 256; c++) begin
            ok = (c >= 8'h20 && c <= 8'h22) || (c >= 8'h40 && c <= 8'h45);
            issue(8'hef, 8'h03, c[7:0], 8'h00, 8'h00, 8'h00, 8'h00, ab);
            if (ok)
                m = c[7:0];
            check(ab, !ok);
            check(xfer_mode, m);
        end
        $display("t_xfer done");
    endtask

    task automatic t_setmax();
        logic ab;
        issue(8'hf9, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h40, ab);
        check(ab, 1'b1);
        issue(8'hf8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, ab);
        issue(8'hf9, 8'h01, 8'h00, 8'h01, 8'h02, 8'h03, 8'h40, ab);
        check({ab, max_addr}, {1'b1, 28'hfffffff});
        issue(8'hf8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, ab);
        issue(8'hf9, 8'h00, 8'h00, 8'hef, 8'hcd, 8'hab, 8'h45, ab);
        check({ab, persist, max_addr}, {2'b00, 28'h5abcdef});
        issue(8'hf8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, ab);
        issue(8'hf9, 8'h00, 8'h01, 8'h77, 8'h02, 8'h01, 8'h03, ab);
        check({ab, persist, max_addr}, {2'b01, 28'h0000102});
        // a seek between read-max and set-max breaks the pairing
        issue(8'hf8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, ab);
        issue(8'h70, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, ab);
        issue(8'hf9, 8'h00, 8'h00, 8'h11, 8'h22, 8'h33, 8'h40, ab);
        check({ab, max_addr}, {1'b1, 28'h0000102});
        sf(8'h09); // persistent limit refused in offset mode
        issue(8'hf8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, ab);
        issue(8'hf9, 8'h00, 8'h01, 8'h00, 8'h05, 8'h06, 8'h00, ab);
        check({ab, max_addr}, {1'b1, 28'h0000102});
        sf(8'h89);
        $display("t_setmax done");
    endtask

    task automatic pulse_soft();
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        @(negedge clk);
    endtask

    task automatic t_softrst();
        sf(8'h55);
        pulse_soft();
        check(ra_en, 1'b1);
        sf(8'h66);
        sf(8'h55);
        pulse_soft();
        check({ra_en, rev_en, max_addr}, {2'b00, 28'h0000102});
        sf(8'hcc);
        sf(8'haa);
        $display("t_softrst done");
    endtask

    // ************************************
    // main sequence
    // ************************************
    initial begin
        clk      = 1'b0;
        rst      = 1'b1;
        soft_rst = 1'b0;
        req      = 1'b0;
        cmd      = 8'h00;
        feat     = 8'h00;
        count    = 8'h00;
        lo       = 8'h00;
        mid      = 8'h00;
        hi       = 8'h00;
        dh       = 8'h00;
        errors   = 0;
        n_tests  = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_seek();
        t_features();
        t_xfer();
        t_setmax();
        t_softrst();
        tally_and_finish();
    end
endmodule // tb
